// >>> ssc_map.svh
// ssc_map.svh: register offsets, field positions, reset values and timing counts
// assumes a 40 MHz hclk and a word-aligned AHB-Lite register window
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

// register byte offsets
`define SSC_OFF_WORD_BASE   12'h000
`define SSC_OFF_DWELL_BASE  12'h020
`define SSC_OFF_CTRL        12'h040
`define SSC_OFF_STATUS      12'h044
`define SSC_OFF_IRQ_STAT    12'h048
`define SSC_OFF_IRQ_MASK    12'h04c
`define SSC_OFF_OUT_SEL     12'h050

// reset values and clamp limits
`define SSC_WORD_RST        16'h00f1
`define SSC_DWELL_RST       16'h012c
`define SSC_WORD_MIN        16'h0001
`define SSC_WORD_MAX        16'hbaff
`define SSC_DWELL_MAX       16'h270f

// selector codes
`define SSC_REF_SRC_SEQ     4'h6
`define SSC_OUT_SRC_SEQ     5'h0f

// step word digit codes
`define SSC_COND_NOW        4'h0
`define SSC_COND_TIME       4'h1
`define SSC_COND_NEVER      4'hf
`define SSC_TGT_STOP        4'h8
`define SSC_TGT_COAST       4'h9
`define SSC_TGT_FAULT       4'ha

// control bit positions
`define SSC_CTRL_START      0
`define SSC_CTRL_STOP       1

// interrupt bit positions
`define SSC_IRQ_STEP        0
`define SSC_IRQ_END         1
`define SSC_IRQ_FAULT       2

// dwell tick: 0.1 s at 40 MHz
`define SSC_TICK_NS         100000000
`define SSC_CLK_NS          25
`define SSC_TICK_CYC        (`SSC_TICK_NS / `SSC_CLK_NS)

`endif

// >>> ssc_pkg.sv
// ssc_pkg.sv: types of the step sequence controller
// assumes ssc_map.svh is compiled alongside
package ssc_pkg;

    // run state of the sequencer
    typedef enum logic [1:0] {
        SSC_IDLE,
        SSC_RUN
    } ssc_state_e;

    // drive commands produced by the current step
    typedef struct packed {
        logic [2:0] preset_idx;
        logic       ramp_set2;
        logic       dir_fwd;
        logic       dir_rev;
        logic       aux_on;
        logic       active;
    } ssc_cmd_s;

    // end-of-program requests, one-cycle pulses
    typedef struct packed {
        logic normal_stop;
        logic coast_stop;
        logic fault;
    } ssc_end_s;

endpackage

// >>> ssc_step_sequencer.sv
// ssc_step_sequencer.sv: eight-step speed profile sequencer with AHB-Lite registers
// assumes one 40 MHz clock; logic inputs arrive from pins, the run command from the control register
// assumes the host stops the sequencer before it rewrites step words
// assumes the drive side captures the one-cycle end request pulses
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`include "ssc_map.svh"

module ssc_step_sequencer #(
    parameter int unsigned TICK_CYC = `SSC_TICK_CYC
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // ahb-lite slave
    input  wire logic             hsel,
    input  wire logic [11:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // drive side
    input  wire logic [3:0]       speed_reference_source,
    input  wire logic             cond_input_a,
    input  wire logic             cond_input_b,
    output ssc_pkg::ssc_cmd_s     cmd,
    output ssc_pkg::ssc_end_s     end_req,
    output logic                  relay_out,
    output logic                  opto1_out,
    output logic                  opto2_out,
    output logic                  irq
);

    // registers
    logic [15:0]            word_q  [8];
    logic [15:0]            dwell_q [8];
    logic [14:0]            out_sel_q, out_sel_d;
    logic [2:0]             mask_q, mask_d;
    logic [2:0]             ist_q, ist_d;
    logic [15:0]            word_d  [8];
    logic [15:0]            dwell_d [8];
    // bus pipeline
    logic                   wr_q, wr_d, rd_q, rd_d;
    logic [11:0]            addr_q, addr_d;
    logic [31:0]            rdata_d;
    // sequencer state
    ssc_pkg::ssc_state_e    st_q, st_d;
    logic [2:0]             step_q, step_d;
    logic [15:0]            dwell_cnt_q, dwell_cnt_d;
    logic [31:0]            tick_q, tick_d;
    ssc_pkg::ssc_cmd_s      cmd_d;
    ssc_pkg::ssc_end_s      end_d;
    // pin synchronisers
    logic [1:0]             a_sync_q, b_sync_q;
    logic                   in_a, in_b;
    logic                   start_pulse, stop_pulse;
    logic [2:0]             ev;

    // evaluate one condition digit
    // d and e pair an expired timer with an inactive input
    function automatic logic cond_met(input logic [3:0] code, input logic tmo,
                                      input logic a, input logic b);
        case (code)
            4'h0: cond_met = 1'b1;
            4'h1: cond_met = tmo;
            4'h2: cond_met = a;
            4'h3: cond_met = b;
            4'h4: cond_met = !a;
            4'h5: cond_met = !b;
            4'h6: cond_met = a | b;
            4'h7: cond_met = a & b;
            4'h8: cond_met = !a & !b;
            4'h9: cond_met = a & !b;
            4'ha: cond_met = b & !a;
            4'hb: cond_met = tmo & a;
            4'hc: cond_met = tmo & b;
            4'hd: cond_met = tmo & !a;
            4'he: cond_met = tmo & !b;
            default: cond_met = 1'b0;
        endcase
    endfunction

    // clamp a written step word into its legal range
    function automatic logic [15:0] clamp_word(input logic [15:0] w);
        if (w < `SSC_WORD_MIN) begin
            clamp_word = `SSC_WORD_MIN;
        end else if (w > `SSC_WORD_MAX) begin
            clamp_word = `SSC_WORD_MAX;
        end else begin
            clamp_word = w;
        end
    endfunction

    // clamp a written dwell time to 999.9 s
    function automatic logic [15:0] clamp_dwell(input logic [15:0] t);
        if (t > `SSC_DWELL_MAX) begin
            clamp_dwell = `SSC_DWELL_MAX;
        end else begin
            clamp_dwell = t;
        end
    endfunction

    // pick one four-bit digit out of a step word
    function automatic logic [3:0] digit(input logic [15:0] w, input logic [1:0] n);
        digit = w[4 * n +: 4];
    endfunction

    // two-flop synchronisers on the logic inputs
    // nothing but the second flop is read, so no metastable level spreads
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_sync_q <= 2'b00;
            b_sync_q <= 2'b00;
        end else begin
            a_sync_q <= {a_sync_q[0], cond_input_a};
            b_sync_q <= {b_sync_q[0], cond_input_b};
        end
    end
    assign in_a = a_sync_q[1];
    assign in_b = b_sync_q[1];

    // ahb-lite: writes take no wait state, reads one, so that hrdata
    // comes from a flop and still stands at the edge that ends the read
    assign hreadyout = !rd_q;
    assign hresp     = 1'b0;

    // capture address phase
    // only a selected transfer seen with hready high is taken
    always_comb begin
        wr_d   = hsel && hready && htrans[1] && hwrite;
        rd_d   = hsel && hready && htrans[1] && !hwrite;
        addr_d = wr_d || rd_d ? haddr : addr_q;
    end

    // control strobes from data-phase writes
    // start and stop act only while their write data stands
    assign start_pulse = wr_q && addr_q == `SSC_OFF_CTRL && hwdata[`SSC_CTRL_START];
    assign stop_pulse  = wr_q && addr_q == `SSC_OFF_CTRL && hwdata[`SSC_CTRL_STOP];

    // register writes and read mux
    always_comb begin
        word_d    = word_q;
        dwell_d   = dwell_q;
        mask_d    = mask_q;
        out_sel_d = out_sel_q;
        ist_d     = ist_q | ev;
        rdata_d   = hrdata; // read data stands until the next read
        // writes act in the data phase, while hwdata stands
        if (wr_q) begin
            if (addr_q < `SSC_OFF_DWELL_BASE && addr_q[1:0] == 2'b00) begin
                word_d[addr_q[4:2]] = clamp_word(hwdata[15:0]);
            end else if (addr_q < `SSC_OFF_CTRL && addr_q[1:0] == 2'b00) begin
                dwell_d[addr_q[4:2]] = clamp_dwell(hwdata[15:0]);
            end else if (addr_q == `SSC_OFF_IRQ_STAT) begin
                ist_d = (ist_q & ~hwdata[2:0]) | ev;
            end else if (addr_q == `SSC_OFF_IRQ_MASK) begin
                mask_d = hwdata[2:0];
            end else if (addr_q == `SSC_OFF_OUT_SEL) begin
                out_sel_d = hwdata[14:0];
            end
        end
        // reads decode the captured address; unmapped ones give zero
        if (rd_q) begin
            rdata_d = 32'h0000_0000;
            if (addr_q < `SSC_OFF_DWELL_BASE) begin
                rdata_d = {16'h0000, word_q[addr_q[4:2]]};
            end else if (addr_q < `SSC_OFF_CTRL) begin
                rdata_d = {16'h0000, dwell_q[addr_q[4:2]]};
            end else if (addr_q == `SSC_OFF_STATUS) begin
                rdata_d = {16'h0000, dwell_cnt_q[11:0], step_q, st_q == ssc_pkg::SSC_RUN};
            end else if (addr_q == `SSC_OFF_IRQ_STAT) begin
                rdata_d = {29'h0000_0000, ist_q};
            end else if (addr_q == `SSC_OFF_IRQ_MASK) begin
                rdata_d = {29'h0000_0000, mask_q};
            end else if (addr_q == `SSC_OFF_OUT_SEL) begin
                rdata_d = {17'h0_0000, out_sel_q};
            end
        end
    end

    // register file state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // step words and dwell times back to their defaults
            for (int i = 0; i < 8; i++) begin
                word_q[i]  <= `SSC_WORD_RST;
                dwell_q[i] <= `SSC_DWELL_RST;
            end
            mask_q    <= 3'b000;
            ist_q     <= 3'b000;
            out_sel_q <= 15'h0000;
            wr_q      <= 1'b0;
            rd_q      <= 1'b0;
            addr_q    <= 12'h000;
            hrdata    <= 32'h0000_0000;
        end else begin
            word_q    <= word_d;
            dwell_q   <= dwell_d;
            mask_q    <= mask_d;
            ist_q     <= ist_d;
            out_sel_q <= out_sel_d;
            wr_q      <= wr_d;
            rd_q      <= rd_d;
            addr_q    <= addr_d;
            hrdata    <= rdata_d;
        end
    end

    // sequencer next state
    always_comb begin
        logic [15:0] w;
        logic        tmo, adv, jmp, go;
        logic [2:0]  nxt;
        logic [3:0]  adv_code, jmp_code, tgt_code;
        // digit fields of the current step word
        w           = word_q[step_q];
        adv_code    = digit(w, 2'h0);
        jmp_code    = digit(w, 2'h1);
        tgt_code    = digit(w, 2'h2);
        tmo         = dwell_cnt_q >= dwell_q[step_q];
        adv         = cond_met(adv_code, tmo, in_a, in_b);
        jmp         = jmp_code != `SSC_COND_NEVER && cond_met(jmp_code, tmo, in_a, in_b);
        go          = 1'b0;
        nxt         = step_q;
        st_d        = st_q;
        step_d      = step_q;
        end_d       = '0;
        ev          = 3'b000;
        tick_d      = tick_q + 32'd1;
        dwell_cnt_d = dwell_cnt_q;
        // 0.1 s prescaler feeds the dwell counter, which saturates
        if (tick_q >= TICK_CYC - 1) begin
            tick_d = 32'd0;
            if (dwell_cnt_q != 16'hffff) begin
                dwell_cnt_d = dwell_cnt_q + 16'd1;
            end
        end
        // start, run, jump and end decisions
        case (st_q)
            ssc_pkg::SSC_IDLE: begin
                if (start_pulse && speed_reference_source == `SSC_REF_SRC_SEQ) begin
                    st_d = ssc_pkg::SSC_RUN;
                    nxt  = 3'd0;
                    go   = 1'b1;
                end
            end
            ssc_pkg::SSC_RUN: begin
                if (stop_pulse || speed_reference_source != `SSC_REF_SRC_SEQ) begin
                    st_d = ssc_pkg::SSC_IDLE;
                end else if (jmp) begin
                    if (tgt_code == `SSC_TGT_STOP) begin
                        st_d              = ssc_pkg::SSC_IDLE;
                        end_d.normal_stop = 1'b1;
                        ev[`SSC_IRQ_END]  = 1'b1;
                    end else if (tgt_code == `SSC_TGT_COAST) begin
                        st_d             = ssc_pkg::SSC_IDLE;
                        end_d.coast_stop = 1'b1;
                        ev[`SSC_IRQ_END] = 1'b1;
                    end else if (tgt_code == `SSC_TGT_FAULT) begin
                        st_d               = ssc_pkg::SSC_IDLE;
                        end_d.fault        = 1'b1;
                        ev[`SSC_IRQ_FAULT] = 1'b1;
                    end else begin
                        nxt = tgt_code[2:0];
                        go  = 1'b1;
                    end
                end else if (adv) begin
                    nxt = step_q + 3'd1;
                    go  = 1'b1;
                end
            end
            default: st_d = ssc_pkg::SSC_IDLE;
        endcase
        // every step entry restarts the dwell timer and flags an event
        if (go) begin
            step_d            = nxt;
            dwell_cnt_d       = 16'd0;
            tick_d            = 32'd0;
            ev[`SSC_IRQ_STEP] = 1'b1;
        end
    end

    // drive command decode from the new step
    always_comb begin
        logic [3:0] s;
        // settings digit: groups of three values, ramp set 2 from value 6
        s                = digit(word_q[step_d], 2'h3);
        cmd_d            = '0;
        cmd_d.active     = st_d == ssc_pkg::SSC_RUN;
        cmd_d.preset_idx = step_d;
        cmd_d.ramp_set2  = s >= 4'h6;
        cmd_d.aux_on     = cmd_d.active && (s inside {4'h3, 4'h4, 4'h5, 4'h9, 4'ha, 4'hb});
        cmd_d.dir_fwd    = cmd_d.active && (s == 4'h0 || s == 4'h3 || s == 4'h6 || s == 4'h9);
        cmd_d.dir_rev    = cmd_d.active && (s == 4'h1 || s == 4'h4 || s == 4'h7 || s == 4'ha);
    end

    // sequencer state registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // stopped at step 0 out of reset
            st_q        <= ssc_pkg::SSC_IDLE;
            step_q      <= 3'd0;
            dwell_cnt_q <= 16'd0;
            tick_q      <= 32'd0;
            cmd         <= '0;
            end_req     <= '0;
        end else begin
            st_q        <= st_d;
            step_q      <= step_d;
            dwell_cnt_q <= dwell_cnt_d;
            tick_q      <= tick_d;
            cmd         <= cmd_d;
            end_req     <= end_d;
        end
    end

    // output routing, one shared aux signal
    assign relay_out = out_sel_q[4:0]   == `SSC_OUT_SRC_SEQ && cmd.aux_on;
    assign opto1_out = out_sel_q[9:5]   == `SSC_OUT_SRC_SEQ && cmd.aux_on;
    assign opto2_out = out_sel_q[14:10] == `SSC_OUT_SRC_SEQ && cmd.aux_on;
    // level interrupt while any unmasked sticky event is set
    assign irq       = |(ist_q & mask_q);

endmodule // ssc_step_sequencer

// >>> ssc_monitor.sv
// ssc_monitor.sv: port-level assertions for the step sequencer
// assumes ssc_pkg is compiled first; bound to ssc_step_sequencer
module ssc_monitor (
    // clock and reset
    input wire logic              hclk,
    input wire logic              hresetn,
    // drive side
    input wire logic [3:0]        speed_reference_source,
    input wire ssc_pkg::ssc_cmd_s cmd,
    input wire ssc_pkg::ssc_end_s end_req,
    input wire logic              relay_out,
    input wire logic              opto1_out,
    input wire logic              opto2_out
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // sequencer runs only under its reference source
    property p_src; speed_reference_source != 4'h6 |=> !cmd.active; endproperty
    a_src: assert property (p_src) else $error("ran without its source");
    property p_start; $rose(cmd.active) |-> cmd.preset_idx == 3'h0; endproperty
    a_start: assert property (p_start) else $error("start not at step 0");
    property p_dir; !(cmd.dir_fwd && cmd.dir_rev); endproperty
    a_dir: assert property (p_dir) else $error("both directions");
    // no pin is driven high unless the single shared aux state is on
    property p_relay; relay_out |-> cmd.aux_on; endproperty
    a_relay: assert property (p_relay) else $error("relay without aux");
    property p_opto; (opto1_out || opto2_out) |-> cmd.aux_on; endproperty
    a_opto: assert property (p_opto) else $error("opto without aux");
    // end requests are lone one-cycle pulses that leave the sequencer idle
    property p_pulse; end_req != 3'b000 |=> end_req == 3'b000; endproperty
    a_pulse: assert property (p_pulse) else $error("end request held");
    property p_one; $onehot0(end_req); endproperty
    a_one: assert property (p_one) else $error("two end kinds");
    property p_idle; end_req != 3'b000 |-> !cmd.active; endproperty
    a_idle: assert property (p_idle) else $error("still running at end");
    c_start: cover property ($rose(cmd.active));
    c_stop: cover property (end_req.normal_stop);
    c_fault: cover property (end_req.fault);
endmodule // ssc_monitor

bind ssc_step_sequencer ssc_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
    .speed_reference_source(speed_reference_source), .cmd(cmd), .end_req(end_req),
    .relay_out(relay_out), .opto1_out(opto1_out), .opto2_out(opto2_out));

// >>> ssc_drive_model.sv
// ssc_drive_model.sv: drive side model, logic input terminals and stop handling
// assumes the sequencer clock; selectors come from the bench
module ssc_drive_model (
    // clock
    input wire logic              hclk,
    // terminals and their selectors
    input wire logic              raw_a,
    input wire logic              raw_b,
    input wire logic [4:0]        sel_a,
    input wire logic [4:0]        sel_b,
    // sequencer side
    input wire ssc_pkg::ssc_end_s end_req,
    output logic                  cond_input_a,
    output logic                  cond_input_b,
    output int                    end_cnt,
    output logic [2:0]            last_end
);
    // a logic input exists only on a terminal assigned to it
    assign cond_input_a = (sel_a == 5'h17) && raw_a;
    assign cond_input_b = (sel_b == 5'h18) && raw_b;
    int cnt = 0;
    // drive takes each stop or fault request
    always @(posedge hclk) begin
        if (end_req != 3'b000) begin
            cnt      <= cnt + 1;
            last_end <= end_req;
        end
    end
    assign end_cnt = cnt;
endmodule // ssc_drive_model

// >>> step_sequence_controller_tb_top.sv
// step_sequence_controller_tb_top.sv: self-checking bench of the step sequencer
// assumes package, sequencer, monitor and drive model compiled first
module step_sequence_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic              hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ra = 0, rb = 0;
    logic              ca, cb, rdy, relay, op1, op2, irq;
    logic [11:0]       haddr = 0;
    logic [1:0]        htrans = 0;
    logic [31:0]       hwdata = 0, hrdata, r;
    logic [3:0]        src = 4'h6;
    logic [2:0]        t, last_end;
    ssc_pkg::ssc_cmd_s cmd;
    ssc_pkg::ssc_end_s end_req;
    int                err_count = 0, compares = 0, seed = 55, n, k, end_cnt;
    always #12.5 hclk = ~hclk;
    ssc_step_sequencer #(.TICK_CYC(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
        .hreadyout(rdy), .hresp(), .speed_reference_source(src), .cond_input_a(ca), .cond_input_b(cb),
        .cmd(cmd), .end_req(end_req), .relay_out(relay), .opto1_out(op1), .opto2_out(op2), .irq(irq));
    ssc_drive_model u_drive (.hclk(hclk), .raw_a(ra), .raw_b(rb), .sel_a(5'h17), .sel_b(5'h18),
        .end_req(end_req), .cond_input_a(ca), .cond_input_b(cb), .end_cnt(end_cnt), .last_end(last_end));
    // one word transfer; read data is taken at the edge that ends the data phase
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1'b1);
        r = hrdata;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for a running step, k counts the cycles
    task automatic wait_idx(input logic [2:0] i);
        for (k = 0; k < 40 && !(cmd.active === 1'b1 && cmd.preset_idx === i); k++) begin
            @(posedge hclk);
            #1;
        end
    endtask
    function automatic ssc_pkg::ssc_cmd_s exp_cmd(input logic [2:0] i, input logic [3:0] s);
        return '{i, s >= 4'h6, s % 3 == 0, s % 3 == 1, s % 6 >= 3, 1'b1};
    endfunction
    function automatic logic cond_ok(input logic [3:0] c, input logic a, input logic b);
        case (c)
            0, 1: return 1'b1;
            2, 11: return a;
            3, 12: return b;
            4, 13: return !a;
            5, 14: return !b;
            6: return a | b;
            7: return a & b;
            8: return !(a | b);
            9: return a & !b;
            10: return b & !a;
            default: return 1'b0;
        endcase
    endfunction
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            bus(0, 12'(4 * i), 0);
            chk("word", 32'h0000_00f1, r);
            bus(0, 12'(32 + 4 * i), 0);
            chk("dwell", 32'h0000_012c, r);
        end
        bus(0, 12'h0fc, 0);
        chk("unmapped", 0, r);
        bus(1, 12'h004, 0);
        bus(0, 12'h004, 0);
        chk("word low", 32'h0000_0001, r);
        bus(1, 12'h004, 32'h0000_ffff);
        bus(0, 12'h004, 0);
        chk("word high", 32'h0000_baff, r);
        bus(1, 12'h024, 32'h0000_ffff);
        bus(0, 12'h024, 0);
        chk("dwell max", 32'h0000_270f, r);
        $display("test registers done");
        // each code decides between an end target and the next step
        bus(1, 12'h020, 0);
        for (int c = 0; c < 18; c++) begin
            ra <= 1'($random(seed));
            rb <= 1'($random(seed));
            t = 3'(c % 3);
            bus(1, 12'h000, {16'h0, 4'h0, 4'h8 + 4'(t), 4'(c), 4'h0});
            n = end_cnt;
            bus(1, 12'h040, 32'h0000_0001);
            repeat (6) @(posedge hclk);
            #1;
            if (cond_ok(4'(c), ra, rb)) begin
                chk("end kind", 3'b100 >> t, last_end);
                chk("end count", n + 1, end_cnt);
            end else
                chk("advance", exp_cmd(3'h1, 4'hb), cmd);
            bus(1, 12'h040, 32'h0000_0002);
        end
        $display("test conditions done");
        // jump to step 7, timed wrap to 0, relay and opto2 follow the aux state, opto1 does not
        bus(1, 12'h050, 32'h0000_3c6f);
        bus(1, 12'h000, 32'h0000_372f);
        bus(1, 12'h01c, 32'h0000_a0f1);
        bus(1, 12'h03c, 32'h0000_0001);
        ra <= 1'b1;
        bus(1, 12'h040, 32'h0000_0001);
        wait_idx(3'h7);
        chk("jump", exp_cmd(3'h7, 4'ha), cmd);
        chk("relay", 1, relay);
        chk("opto1", 0, op1);
        @(posedge hclk);
        ra <= 1'b0;
        wait_idx(3'h0);
        chk("wrap", exp_cmd(3'h0, 4'h3), cmd);
        chk("dwell wait", 1, k >= 3 && k < 12);
        chk("opto2", 1, op2);
        @(posedge hclk);
        src <= 4'h0;
        repeat (3) @(posedge hclk);
        #1;
        chk("source off", 0, cmd.active);
        bus(1, 12'h040, 32'h0000_0001);
        #1;
        chk("start ignored", 0, cmd.active);
        bus(0, 12'h044, 0);
        chk("status idle", 0, r[0]);
        src <= 4'h6;
        $display("test steps done");
        // sticky events, mask, write one to clear
        bus(0, 12'h048, 0);
        chk("events", 3'h7, r[2:0]);
        chk("masked", 0, irq);
        bus(1, 12'h04c, 32'h0000_0007);
        #1;
        chk("irq", 1, irq);
        bus(1, 12'h048, 32'h0000_0007);
        bus(0, 12'h048, 0);
        chk("cleared", 0, r[2:0]);
        chk("irq off", 0, irq);
        $display("test interrupts done");
        give_verdict();
    end
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        give_verdict();
    end
endmodule // step_sequence_controller_tb_top
